// file: logic/sbsd_pkg.sv
// Constants shared by the serial baud, status and data block.
// Assumes a single 100 MHz bus clock and a byte-wide register port.
package sbsd_pkg;
	localparam int ADDR_W = 3;
	localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;
	localparam logic [2:0] ADDR_BIT_RATE = 3'h2;
	localparam logic [2:0] ADDR_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h4;
	// control_one fields
	localparam int C1_RX_IRQ_EN = 7;
	localparam int C1_ENABLE = 6;
	localparam int C1_TX_IRQ_EN = 5;
	localparam int C1_MASTER = 4;
	localparam int C1_CPOL = 3;
	localparam int C1_CPHA = 2;
	localparam int C1_SEL_OUT_EN = 1;
	localparam int C1_LSB_FIRST = 0;
	// control_two fields
	localparam int C2_FAULT_EN = 4;
	localparam logic [7:0] C2_MASK = 8'h10;
	// bit_rate_select fields
	localparam int BR_PRE_HI = 6;
	localparam int BR_PRE_LO = 4;
	localparam int BR_RATE_HI = 2;
	localparam int BR_RATE_LO = 0;
	localparam logic [7:0] BR_MASK = 8'h77;
	// serial_flags fields
	localparam int FL_RX_FULL = 7;
	localparam int FL_TX_EMPTY = 5;
	localparam int FL_MODE_FAULT = 4;
	// Reset values
	localparam logic [7:0] CONTROL_ONE_RST = 8'h04;
	localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
	localparam logic [7:0] BIT_RATE_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	// Edges in one byte transfer (two per bit)
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
endpackage

// file: logic/sbsd_baud_if.sv
// Carries the baud divider settings and its half-bit tick.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ns
interface sbsd_baud_if;
	logic run;
	logic [2:0] prescale;
	logic [2:0] rate;
	logic half_tick;
	modport gen (input run, input prescale, input rate, output half_tick);
	modport user (output run, output prescale, output rate, input half_tick);
endinterface

// file: logic/sbsd_baud_gen.sv
// Baud generator: prescaler then power-of-two divider.
// Assumes run is held high for the whole of a master transfer.
`timescale 1ns/1ns
module sbsd_baud_gen (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	sbsd_baud_if.gen baud
);
	logic [2:0] pre_cnt;
	logic [7:0] rate_cnt;
	logic tick;
	logic [2:0] next_pre_cnt;
	logic [7:0] next_rate_cnt;
	logic next_tick;
	logic [7:0] rate_lim;

	// Half a bit period is 2^rate prescaled ticks, so a full bit is 2^(rate+1)
	always_comb begin
		rate_lim = (8'h01 << baud.rate) - 8'h01;
		next_pre_cnt = pre_cnt;
		next_rate_cnt = rate_cnt;
		next_tick = 1'b0;
		if (!baud.run) begin
			// Restart from zero so the first edge is a full half period away
			next_pre_cnt = 3'h0;
			next_rate_cnt = 8'h00;
		end else if (pre_cnt == baud.prescale) begin
			next_pre_cnt = 3'h0;
			if (rate_cnt == rate_lim) begin
				next_rate_cnt = 8'h00;
				next_tick = 1'b1;
			end else begin
				next_rate_cnt = rate_cnt + 8'h01;
			end
		end else begin
			next_pre_cnt = pre_cnt + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pre_cnt <= 3'h0;
			rate_cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			pre_cnt <= next_pre_cnt;
			rate_cnt <= next_rate_cnt;
			tick <= next_tick;
		end
	end

	assign baud.half_tick = tick;
endmodule

// file: logic/sbsd_shifter.sv
// Byte shifter for master and slave transfers in all four clock formats.
// Assumes pin inputs arrive already synchronised and filtered.
`timescale 1ns/1ns
module sbsd_shifter (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic enable_i,
	input wire logic master_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic lsb_first_i,
	input wire logic load_i,
	input wire logic [7:0] load_data_i,
	input wire logic sck_i,
	input wire logic ss_n_i,
	input wire logic data_in_i,
	sbsd_baud_if.user baud,
	output logic busy_o,
	output logic done_o,
	output logic [7:0] rx_byte_o,
	output logic sck_o,
	output logic data_out_o
);
	typedef enum logic {SBSD_IDLE, SBSD_RUN} sbsd_shift_state_e;
	sbsd_shift_state_e state, next_state;
	logic [7:0] shreg, next_shreg;
	logic samp, next_samp;
	logic [4:0] cnt, next_cnt;
	logic sck_prev, next_sck_prev;
	logic done, next_done;
	logic edge_ev;
	logic [3:0] e;

	function automatic logic [7:0] shift_in(input logic [7:0] r, input logic b,
			input logic lsbf);
		shift_in = lsbf ? {b, r[7:1]} : {r[6:0], b};
	endfunction

	always_comb begin
		next_state = state;
		next_shreg = shreg;
		next_samp = samp;
		next_cnt = cnt;
		next_sck_prev = sck_i;
		next_done = 1'b0;
		edge_ev = 1'b0;
		e = 4'h0;
		if (master_i) begin
			edge_ev = (state == SBSD_RUN) && baud.half_tick && (cnt != 5'h0);
			e = 4'(cnt - 5'h1);
			if (state == SBSD_RUN && baud.half_tick) begin
				next_cnt = cnt + 5'h1;
			end
		end else begin
			edge_ev = !ss_n_i && (sck_i != sck_prev);
			e = cnt[3:0];
			if (ss_n_i) begin
				next_cnt = 5'h0;
			end else if (edge_ev) begin
				next_cnt = (cnt == sbsd_pkg::EDGES_PER_BYTE - 5'h1) ? 5'h0 : cnt + 5'h1;
			end
		end
		if (load_i) begin
			next_shreg = load_data_i;
			next_cnt = 5'h0;
			next_state = master_i ? SBSD_RUN : SBSD_IDLE;
		end else if (edge_ev) begin
			// Even edges sample with phase 0, odd edges sample with phase 1
			if (e[0] == cpha_i) begin
				next_samp = data_in_i;
			end else if (e != 4'h0) begin
				next_shreg = shift_in(shreg, samp, lsb_first_i);
			end
			if (e == 4'hF) begin
				next_shreg = shift_in(shreg, cpha_i ? data_in_i : samp, lsb_first_i);
				next_done = 1'b1;
				next_state = SBSD_IDLE;
			end
		end
		if (!enable_i) begin
			next_state = SBSD_IDLE;
			next_cnt = 5'h0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state <= SBSD_IDLE;
			shreg <= 8'h00;
			samp <= 1'b0;
			cnt <= 5'h0;
			sck_prev <= 1'b0;
			done <= 1'b0;
		end else begin
			state <= next_state;
			shreg <= next_shreg;
			samp <= next_samp;
			cnt <= next_cnt;
			sck_prev <= next_sck_prev;
			done <= next_done;
		end
	end

	assign baud.run = master_i && (state == SBSD_RUN);
	assign busy_o = master_i ? (state == SBSD_RUN) : (cnt != 5'h0);
	assign done_o = done;
	assign rx_byte_o = shreg;
	// Clock idles at polarity and toggles after each edge that has passed
	assign sck_o = cpol_i ^ ((state == SBSD_RUN) && master_i && (cnt != 5'h0) && cnt[0]);
	assign data_out_o = lsb_first_i ? shreg[0] : shreg[7];
endmodule

// file: logic/sbsd_core.sv
// Serial peripheral core: registers, status flags, data buffers and pins.
// Assumes a byte register port with read data one cycle after the strobe.
// Summary of operation
// - Prescale field bits 6:4 divides bus clock by field plus one.
// - Rate field bits 2:0 divides further by two to the field plus one.
// - Bit rate register may be read and written at any time.
// - Flags register reads zero on unused bits and ignores writes.
// - Receive full sets when a finished byte lands in the receive buffer.
// - Receive full clears by flags read while set, then data read.
// - Transmit empty reflects room; cleared by flags read then data write.
// - Data write without prior flags read showing empty is ignored.
// - Interrupt raised while transmit empty and transmit enable are set.
// - Idle module moves a written byte to shifter within two cycles.
// - After a transfer a queued byte loads automatically; else nothing moves.
// - Mode fault sets on select low, master with fault on, select out off.
// - Mode fault clears by flags read while set, then control one write.
// - Data reads give receive buffer, writes fill transmit buffer, reset zero.
// - In master mode a buffered byte starts a transfer once shifter is free.
// - A byte finishing while receive buffer is unread is discarded.
// - Receive enable gates interrupts from receive full and mode fault.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module sbsd_core (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic irq_o,
	input wire logic sck_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	input wire logic ss_n_i,
	output logic ss_n_o,
	output logic ss_oe_n_o
);
	// Pin synchronisers: three stages, a change counts when stages two and three agree
	logic [3:0] sync1, sync2, sync3, pin_f;
	logic [3:0] next_sync1, next_sync2, next_sync3, next_pin_f;
	logic sck_f, mosi_f, miso_f, ss_f;

	always_comb begin
		next_sync1 = {ss_n_i, miso_i, mosi_i, sck_i};
		next_sync2 = sync1;
		next_sync3 = sync2;
		next_pin_f = pin_f;
		for (int i = 0; i < 4; i++) begin
			if (sync2[i] == sync3[i]) begin
				next_pin_f[i] = sync3[i];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			sync1 <= 4'hF;
			sync2 <= 4'hF;
			sync3 <= 4'hF;
			pin_f <= 4'hF;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
			pin_f <= next_pin_f;
		end
	end

	assign sck_f = pin_f[0];
	assign mosi_f = pin_f[1];
	assign miso_f = pin_f[2];
	assign ss_f = pin_f[3];

	// Register and flag state
	logic [7:0] control_one, next_control_one;
	logic [7:0] control_two, next_control_two;
	logic [7:0] bit_rate_select, next_bit_rate_select;
	logic [7:0] rx_buf, next_rx_buf;
	logic [7:0] tx_buf, next_tx_buf;
	logic tx_full, next_tx_full;
	logic rx_full, next_rx_full;
	logic mode_fault, next_mode_fault;
	logic rx_armed, next_rx_armed;
	logic tx_armed, next_tx_armed;
	logic fault_armed, next_fault_armed;
	logic [7:0] rdata, next_rdata;
	logic irq, next_irq;

	logic enable, master, fault_en, sel_out_en;
	logic transmit_empty;
	logic wr_c1, rd_flags, rd_data, wr_data, data_accept;
	logic fault_event, load;
	logic [7:0] flags_view;
	logic sh_busy, sh_done, sh_sck, sh_dout;
	logic [7:0] sh_rx;

	assign enable = control_one[sbsd_pkg::C1_ENABLE];
	assign master = control_one[sbsd_pkg::C1_MASTER];
	assign fault_en = control_two[sbsd_pkg::C2_FAULT_EN];
	assign sel_out_en = control_one[sbsd_pkg::C1_SEL_OUT_EN];
	assign transmit_empty = !tx_full;

	assign wr_c1 = wr_i && (addr_i == sbsd_pkg::ADDR_CONTROL_ONE);
	assign rd_flags = rd_i && (addr_i == sbsd_pkg::ADDR_FLAGS);
	assign rd_data = rd_i && (addr_i == sbsd_pkg::ADDR_DATA);
	assign wr_data = wr_i && (addr_i == sbsd_pkg::ADDR_DATA);
	assign data_accept = wr_data && tx_armed;

	// Select pin only watches for a fault in this one configuration
	assign fault_event = enable && master && fault_en && !sel_out_en && !ss_f;

	// Shifter takes the buffered byte as soon as it is free
	assign load = tx_full && enable && !sh_busy && !sh_done;

	always_comb begin
		flags_view = 8'h00;
		flags_view[sbsd_pkg::FL_RX_FULL] = rx_full;
		flags_view[sbsd_pkg::FL_TX_EMPTY] = transmit_empty;
		flags_view[sbsd_pkg::FL_MODE_FAULT] = mode_fault;
	end

	sbsd_baud_if baud ();

	sbsd_baud_gen u_baud (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.baud(baud.gen)
	);

	assign baud.prescale = bit_rate_select[sbsd_pkg::BR_PRE_HI:sbsd_pkg::BR_PRE_LO];
	assign baud.rate = bit_rate_select[sbsd_pkg::BR_RATE_HI:sbsd_pkg::BR_RATE_LO];

	sbsd_shifter u_shift (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.enable_i(enable),
		.master_i(master),
		.cpol_i(control_one[sbsd_pkg::C1_CPOL]),
		.cpha_i(control_one[sbsd_pkg::C1_CPHA]),
		.lsb_first_i(control_one[sbsd_pkg::C1_LSB_FIRST]),
		.load_i(load),
		.load_data_i(tx_buf),
		.sck_i(sck_f),
		.ss_n_i(ss_f),
		.data_in_i(master ? miso_f : mosi_f),
		.baud(baud.user),
		.busy_o(sh_busy),
		.done_o(sh_done),
		.rx_byte_o(sh_rx),
		.sck_o(sh_sck),
		.data_out_o(sh_dout)
	);

	// Register writes and read data
	always_comb begin
		next_control_one = control_one;
		next_control_two = control_two;
		next_bit_rate_select = bit_rate_select;
		next_rdata = 8'h00;
		if (wr_c1) begin
			next_control_one = wdata_i;
		end
		if (wr_i && addr_i == sbsd_pkg::ADDR_CONTROL_TWO) begin
			next_control_two = wdata_i & sbsd_pkg::C2_MASK;
		end
		if (wr_i && addr_i == sbsd_pkg::ADDR_BIT_RATE) begin
			next_bit_rate_select = wdata_i & sbsd_pkg::BR_MASK;
		end
		if (rd_i) begin
			unique case (addr_i)
				sbsd_pkg::ADDR_CONTROL_ONE: next_rdata = control_one;
				sbsd_pkg::ADDR_CONTROL_TWO: next_rdata = control_two;
				sbsd_pkg::ADDR_BIT_RATE: next_rdata = bit_rate_select;
				sbsd_pkg::ADDR_FLAGS: next_rdata = flags_view;
				sbsd_pkg::ADDR_DATA: next_rdata = rx_buf;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			control_one <= sbsd_pkg::CONTROL_ONE_RST;
			control_two <= sbsd_pkg::CONTROL_TWO_RST;
			bit_rate_select <= sbsd_pkg::BIT_RATE_RST;
			rdata <= 8'h00;
		end else begin
			control_one <= next_control_one;
			control_two <= next_control_two;
			bit_rate_select <= next_bit_rate_select;
			rdata <= next_rdata;
		end
	end

	// Flags and buffers; a hardware set always wins over a software clear
	always_comb begin
		next_rx_buf = rx_buf;
		next_tx_buf = tx_buf;
		next_tx_full = tx_full;
		next_rx_full = rx_full;
		next_mode_fault = mode_fault;
		next_rx_armed = rx_armed;
		next_tx_armed = tx_armed;
		next_fault_armed = fault_armed;

		// Receive side
		if (rd_flags && rx_full) begin
			next_rx_armed = 1'b1;
		end
		if (rd_data && rx_armed) begin
			next_rx_full = 1'b0;
			next_rx_armed = 1'b0;
		end
		if (sh_done) begin
			if (!next_rx_full) begin
				next_rx_buf = sh_rx;
				next_rx_full = 1'b1;
			end
			// Unread previous byte stays; the new one is dropped silently
		end

		// Transmit side
		if (rd_flags && transmit_empty) begin
			next_tx_armed = 1'b1;
		end
		if (load) begin
			next_tx_full = 1'b0;
		end
		if (wr_data) begin
			next_tx_armed = 1'b0;
			if (data_accept) begin
				next_tx_buf = wdata_i;
				next_tx_full = 1'b1;
			end
		end

		// Mode fault
		if (rd_flags && mode_fault) begin
			next_fault_armed = 1'b1;
		end
		if (wr_c1 && fault_armed) begin
			next_mode_fault = 1'b0;
			next_fault_armed = 1'b0;
		end
		if (fault_event) begin
			next_mode_fault = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rx_buf <= sbsd_pkg::DATA_RST;
			tx_buf <= sbsd_pkg::DATA_RST;
			tx_full <= 1'b0;
			rx_full <= 1'b0;
			mode_fault <= 1'b0;
			rx_armed <= 1'b0;
			tx_armed <= 1'b0;
			fault_armed <= 1'b0;
		end else begin
			rx_buf <= next_rx_buf;
			tx_buf <= next_tx_buf;
			tx_full <= next_tx_full;
			rx_full <= next_rx_full;
			mode_fault <= next_mode_fault;
			rx_armed <= next_rx_armed;
			tx_armed <= next_tx_armed;
			fault_armed <= next_fault_armed;
		end
	end

	// Interrupt request and pin drivers, all registered
	logic next_sck_o, next_sck_oe_n, next_mosi_o, next_mosi_oe_n;
	logic next_miso_o, next_miso_oe_n, next_ss_n_o, next_ss_oe_n;
	logic sck_r, sck_oe_n, mosi_r, mosi_oe_n, miso_r, miso_oe_n, ss_r, ss_oe_n;

	always_comb begin
		next_irq = (control_one[sbsd_pkg::C1_TX_IRQ_EN] && transmit_empty)
			|| (control_one[sbsd_pkg::C1_RX_IRQ_EN] && (rx_full || mode_fault));
		next_sck_o = sh_sck;
		next_mosi_o = sh_dout;
		next_miso_o = sh_dout;
		next_sck_oe_n = !(enable && master);
		next_mosi_oe_n = !(enable && master);
		// Slave only drives its data line while selected, so bus sharing is safe
		next_miso_oe_n = !(enable && !master && !ss_f);
		next_ss_n_o = !sh_busy;
		next_ss_oe_n = !(enable && master && fault_en && sel_out_en);
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			irq <= 1'b0;
			sck_r <= 1'b0;
			sck_oe_n <= 1'b1;
			mosi_r <= 1'b0;
			mosi_oe_n <= 1'b1;
			miso_r <= 1'b0;
			miso_oe_n <= 1'b1;
			ss_r <= 1'b1;
			ss_oe_n <= 1'b1;
		end else begin
			irq <= next_irq;
			sck_r <= next_sck_o;
			sck_oe_n <= next_sck_oe_n;
			mosi_r <= next_mosi_o;
			mosi_oe_n <= next_mosi_oe_n;
			miso_r <= next_miso_o;
			miso_oe_n <= next_miso_oe_n;
			ss_r <= next_ss_n_o;
			ss_oe_n <= next_ss_oe_n;
		end
	end

	assign rdata_o = rdata;
	assign irq_o = irq;
	assign sck_o = sck_r;
	assign sck_oe_n_o = sck_oe_n;
	assign mosi_o = mosi_r;
	assign mosi_oe_n_o = mosi_oe_n;
	assign miso_o = miso_r;
	assign miso_oe_n_o = miso_oe_n;
	assign ss_n_o = ss_r;
	assign ss_oe_n_o = ss_oe_n;
endmodule

// file: tb/sbsd_core_chk.sv
// Checker for the serial core register port, interrupt and pin drive.
// Assumes it is bound to sbsd_core and sees only its ports.
`timescale 1ns/1ns
module sbsd_core_chk (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic irq_o,
	input wire logic sck_o,
	input wire logic mosi_oe_n_o,
	input wire logic ss_n_o,
	input wire logic ss_oe_n_o
);
	logic [7:0] c1, c2, br, next_c1, next_c2, next_br;
	logic [15:0] gap, next_gap, half_w;
	logic prev_sck;
	// Cycles since select fell with no serial clock edge yet; saturates, never wraps
	logic prev_ss;
	logic [10:0] lead_cnt, next_lead_cnt;
	assign half_w = ({13'h0000, br[6:4]} + 16'h0001) << br[2:0];
	always_comb begin
		next_c1 = c1;
		next_c2 = c2;
		next_br = br;
		next_gap = (gap == 16'hFFFF) ? gap : gap + 16'h0001;
		if (sck_o != prev_sck) next_gap = 16'h0001;
		next_lead_cnt = lead_cnt;
		if (ss_n_o || sck_o != prev_sck) next_lead_cnt = 11'h000;
		else if (prev_ss) next_lead_cnt = 11'h001;
		else if (lead_cnt != 11'h000 && lead_cnt != 11'h7FF) next_lead_cnt = lead_cnt + 11'h001;
		if (wr_i && addr_i == sbsd_pkg::ADDR_CONTROL_ONE) next_c1 = wdata_i;
		if (wr_i && addr_i == sbsd_pkg::ADDR_CONTROL_TWO) next_c2 = wdata_i & sbsd_pkg::C2_MASK;
		if (wr_i && addr_i == sbsd_pkg::ADDR_BIT_RATE) next_br = wdata_i & sbsd_pkg::BR_MASK;
	end
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			c1 <= sbsd_pkg::CONTROL_ONE_RST;
			c2 <= sbsd_pkg::CONTROL_TWO_RST;
			br <= sbsd_pkg::BIT_RATE_RST;
			gap <= 16'hFFFF;
			prev_sck <= 1'b0;
			prev_ss <= 1'b1;
			lead_cnt <= 11'h000;
		end else begin
			c1 <= next_c1;
			c2 <= next_c2;
			br <= next_br;
			gap <= next_gap;
			prev_sck <= sck_o;
			prev_ss <= ss_n_o;
			lead_cnt <= next_lead_cnt;
		end
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	// Settings unchanged over the last cycle, so a registered drive has caught up
	sequence cfg_steady;
		c1 == $past(c1) && c2 == $past(c2);
	endsequence
	sequence flags_read;
		$past(rd_i) && $past(addr_i) == sbsd_pkg::ADDR_FLAGS;
	endsequence
	a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data seen outside the read slot");
	a_flags_unused_zero: assert property (flags_read |-> (rdata_o & 8'h4F) == 8'h00)
		else $error("unused flag bits read as one");
	a_rate_read_back: assert property (($past(wr_i, 2)
		&& $past(addr_i, 2) == sbsd_pkg::ADDR_BIT_RATE && $past(rd_i)
		&& $past(addr_i) == sbsd_pkg::ADDR_BIT_RATE)
		|-> rdata_o == ($past(wdata_i, 2) & sbsd_pkg::BR_MASK))
		else $error("bit rate read does not return the value written");
	a_irq_tx_empty: assert property ((flags_read ##0 (rdata_o[5] && $past(c1[5]))) |-> irq_o)
		else $error("no interrupt with transmit empty enabled");
	a_irq_rx_fault: assert property ((flags_read ##0 ((rdata_o[7] || rdata_o[4])
		&& $past(c1[7]))) |-> irq_o)
		else $error("no interrupt with receive or fault flag enabled");
	a_irq_quiet: assert property ((flags_read ##0 (rdata_o[7:4] & 4'hB) == 4'h0) |-> !irq_o)
		else $error("interrupt raised with all flags clear");
	a_select_drive: assert property (cfg_steady
		|-> ss_oe_n_o == !(c1[6] && c1[4] && c2[4] && c1[1]))
		else $error("select pin drive does not follow the mode");
	a_mosi_drive: assert property (cfg_steady |-> mosi_oe_n_o == !(c1[6] && c1[4]))
		else $error("master data pin drive does not follow the mode");
	a_sck_half_gap: assert property ((sck_o != prev_sck) |-> gap >= half_w)
		else $error("serial clock edge earlier than the divided half period");
	a_frame_starts: assert property (lead_cnt <= 11'd1100)
		else $error("no serial clock after select went low");
	c_frame: cover property ($fell(ss_n_o));
	c_irq: cover property ($rose(irq_o));
	c_rx_full: cover property (flags_read ##0 rdata_o[7]);
endmodule
bind sbsd_core sbsd_core_chk u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.irq_o(irq_o), .sck_o(sck_o), .mosi_oe_n_o(mosi_oe_n_o), .ss_n_o(ss_n_o),
	.ss_oe_n_o(ss_oe_n_o));

// file: tb/sbsd_partner.sv
// Serial slave model, clock idle low, sampling on the trailing edge, MSB first.
// Assumes the master keeps select low for the whole of each frame.
`timescale 1ns/1ns
module sbsd_partner (
	input wire logic sck_i,
	input wire logic ss_n_i,
	input wire logic mosi_i,
	input wire logic [7:0] reply_i,
	output logic miso_o,
	output logic [7:0] got_o,
	output int bits_o
);
	logic last = 1'b0;
	initial got_o = 8'h00;
	initial bits_o = 0;
	// Odd frames send the reply inverted, so a dropped byte is told apart
	always @(posedge sck_i) if (!ss_n_i) last = reply_i[7 - bits_o % 8] ^ bits_o[3];
	always @(negedge sck_i) begin
		if (!ss_n_i) begin
			got_o = {got_o[6:0], mosi_i};
			bits_o++;
		end
	end
	// Released line shows no stale level
	assign miso_o = ss_n_i ? ~last : last;
endmodule

// file: tb/spi_baud_status_data_test.sv
// Self-checking bench for sbsd_core with a slave model on its pins.
// Assumes the checker is bound in and a 100 MHz bus clock.
`timescale 1ns/1ns
module spi_baud_status_data_test;
	logic clk_sys_i = 1'b0;
	logic reset_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic tb_ss_n = 1'b1;
	logic [7:0] reply = 8'h00;
	logic [7:0] rdata_o, p_got, v, a, b, exp_rx;
	logic irq_o, sck_o, sck_oe_n_o, mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
	logic ss_n_o, ss_oe_n_o, sck_w, mosi_w, miso_w, ss_w, p_miso;
	int p_bits, b0, i;
	int err_total = 0;
	int checks_done = 0;
	logic [7:0] mf_c2 [5] = '{8'h10, 8'h00, 8'h10, 8'h10, 8'h10};
	logic [7:0] mf_c1 [5] = '{8'hC6, 8'hD4, 8'hC4, 8'h54, 8'hD4};
	always #5 clk_sys_i = ~clk_sys_i;
	assign sck_w = sck_oe_n_o ? 1'b0 : sck_o;
	assign mosi_w = mosi_oe_n_o ? 1'b0 : mosi_o;
	assign miso_w = miso_oe_n_o ? p_miso : miso_o;
	assign ss_w = ss_oe_n_o ? tb_ss_n : ss_n_o;
	sbsd_core dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .mosi_i(mosi_w),
		.mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o), .miso_i(miso_w), .miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o), .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_oe_n_o(ss_oe_n_o));
	sbsd_partner peer (.sck_i(sck_w), .ss_n_i(ss_w), .mosi_i(mosi_w), .reply_i(reply),
		.miso_o(p_miso), .got_o(p_got), .bits_o(p_bits));
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task tick;
		@(posedge clk_sys_i);
		#1;
	endtask
	// Starts one step after an edge so back-to-back writes always retoggle the strobe
	task wr(input logic [2:0] ad, input logic [7:0] d);
		#1;
		addr_i <= ad;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [2:0] ad);
		addr_i <= ad;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task rdchk(input logic [2:0] ad, input logic [7:0] m, input logic [7:0] e, input string w);
		rd(ad);
		check(w, {8'h00, v & m}, {8'h00, e});
	endtask
	task wait_bits(input int n);
		for (i = 0; i < 40000 && !(p_bits >= n && ss_n_o === 1'b1); i++) tick();
		if (i >= 40000) begin
			check("frame_end", 16'h0000, 16'h0001);
			results();
		end
		repeat (4) tick();
	endtask
	task frame_start;
		b0 = p_bits;
		reply = 8'($urandom);
		exp_rx = reply ^ {8{b0[3]}};
		a = 8'($urandom);
		b = ~a;
	endtask
	task xfer(input logic [2:0] pre, input logic [2:0] rate);
		int n;
		frame_start();
		wr(sbsd_pkg::ADDR_BIT_RATE, {1'b0, pre, 1'b0, rate});
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'hFF, 8'h20, "flags_idle");
		wr(sbsd_pkg::ADDR_DATA, a);
		tick();
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h20, 8'h20, "empty_after_load");
		for (n = 0; n < 5000 && sck_o !== 1'b1; n++) tick();
		for (n = 0; n < 5000 && sck_o === 1'b1; n++) tick();
		check("half_period", 16'(n), 16'((int'(pre) + 1) << rate));
		wait_bits(b0 + 8);
		check("peer_got", {8'h00, p_got}, {8'h00, a});
		rd(sbsd_pkg::ADDR_DATA);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'hFF, 8'hA0, "full_kept");
		rd(sbsd_pkg::ADDR_DATA);
		if (((int'(pre) + 1) << rate) >= 8) check("rx_byte", {8'h00, v}, {8'h00, exp_rx});
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h80, 8'h00, "full_cleared");
		$display("test frame pre %0d rate %0d done", pre, rate);
	endtask
	initial begin
		void'($urandom(94549));
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		rdchk(sbsd_pkg::ADDR_BIT_RATE, 8'hFF, sbsd_pkg::BIT_RATE_RST, "rate_reset");
		rdchk(sbsd_pkg::ADDR_DATA, 8'hFF, sbsd_pkg::DATA_RST, "data_reset");
		wr(sbsd_pkg::ADDR_FLAGS, 8'hFF);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'hFF, 8'h20, "flags_write");
		rdchk(3'h6, 8'hFF, 8'h00, "unmapped");
		for (int k = 0; k < 6; k++) begin
			a = 8'($urandom);
			wr(sbsd_pkg::ADDR_BIT_RATE, a);
			rdchk(sbsd_pkg::ADDR_BIT_RATE, 8'hFF, a & sbsd_pkg::BR_MASK, "rate_rw");
		end
		$display("test registers done");
		wr(sbsd_pkg::ADDR_CONTROL_TWO, 8'h10);
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'h56);
		for (int k = 0; k < 6; k++)
			xfer(k == 0 ? 3'h0 : k == 1 ? 3'h7 : 3'($urandom_range(7)),
				k == 0 ? 3'h0 : k == 1 ? 3'h7 : 3'($urandom_range(4, 2)));
		frame_start();
		wr(sbsd_pkg::ADDR_BIT_RATE, 8'h13);
		rd(sbsd_pkg::ADDR_FLAGS);
		wr(sbsd_pkg::ADDR_DATA, a);
		tick();
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h20, 8'h20, "empty_before_queue");
		wr(sbsd_pkg::ADDR_DATA, b);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'hFF, 8'h00, "queued_full");
		wait_bits(b0 + 16);
		check("queued_sent", {8'h00, p_got}, {8'h00, b});
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'hFF, 8'hA0, "after_two");
		rdchk(sbsd_pkg::ADDR_DATA, 8'hFF, exp_rx, "overrun_kept");
		$display("test queue and overrun done");
		frame_start();
		rd(sbsd_pkg::ADDR_FLAGS);
		wr(sbsd_pkg::ADDR_DATA, a);
		wr(sbsd_pkg::ADDR_DATA, b);
		tick();
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h20, 8'h20, "unarmed_ignored");
		wait_bits(b0 + 8);
		repeat (60) tick();
		check("one_frame", 16'(p_bits - b0), 16'h0008);
		rd(sbsd_pkg::ADDR_FLAGS);
		rd(sbsd_pkg::ADDR_DATA);
		$display("test ignored write done");
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'h64);
		rd(sbsd_pkg::ADDR_FLAGS);
		tick();
		check("irq_tx", {15'h0000, irq_o}, 16'h0001);
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'h44);
		repeat (2) tick();
		check("irq_masked", {15'h0000, irq_o}, 16'h0000);
		for (int k = 0; k < 5; k++) begin
			wr(sbsd_pkg::ADDR_CONTROL_TWO, mf_c2[k]);
			wr(sbsd_pkg::ADDR_CONTROL_ONE, mf_c1[k]);
			tb_ss_n <= 1'b0;
			repeat (8) tick();
			tb_ss_n <= 1'b1;
			repeat (8) tick();
			rdchk(sbsd_pkg::ADDR_FLAGS, 8'h10, k > 2 ? 8'h10 : 8'h00, "fault_set");
			tick();
			check("irq_fault", {15'h0000, irq_o}, {15'h0000, k == 4});
		end
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'hD4);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h10, 8'h00, "fault_clear");
		tb_ss_n <= 1'b0;
		repeat (8) tick();
		tb_ss_n <= 1'b1;
		repeat (8) tick();
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'hD4);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h10, 8'h10, "fault_kept");
		wr(sbsd_pkg::ADDR_CONTROL_ONE, 8'hD4);
		rdchk(sbsd_pkg::ADDR_FLAGS, 8'h10, 8'h00, "fault_clear2");
		$display("test interrupts and mode fault done");
		results();
	end
endmodule
